// [hsc_cmd_port.sv]
// Purpose : serial command port: takes command bytes, returns replies
// Assumes : host keeps link timing; link clock sampled by sys_clk_i
// Notes   : a command is handed on only when select rises
//
// Summary of operation
// - command then data bytes, MSB first, assembled
// - reply bytes leave MSB first
// - command bits captured on rising clock
// - command handed on only when select rises
// - clock may idle low or high
// - drive reply after clock low; release fast
`default_nettype none

module hsc_cmd_port (
  input  wire logic                          sys_clk_i,
  input  wire logic                          rst_n_i,
  input  wire logic                          serial_clock_i,
  input  wire logic                          chip_select_n_i,
  input  wire logic                          command_data_i,
  output logic                               reply_line_o,
  output logic                               reply_line_oe_o,
  input  wire logic [hsc_pkg::BYTE_W-1:0]    reply_byte_i,
  output logic                               reply_next_o,
  output logic                               cmd_valid_o,
  output logic [hsc_pkg::BYTE_W-1:0]         cmd_byte_o,
  output logic [hsc_pkg::DATA_W-1:0]         cmd_data_o,
  output logic [hsc_pkg::BYTE_CNT_W-1:0]     cmd_data_count_o
);

  hsc_link_if link ();

  hsc_edge_find u_edge (
    .sys_clk_i       (sys_clk_i),
    .rst_n_i         (rst_n_i),
    .serial_clock_i  (serial_clock_i),
    .chip_select_n_i (chip_select_n_i),
    .command_data_i  (command_data_i),
    .link            (link)
  );

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  hsc_pkg::hsc_state_e                 state;
  hsc_pkg::hsc_state_e                 next_state;
  logic [hsc_pkg::BYTE_W-1:0]          shift_in;
  logic [hsc_pkg::BYTE_W-1:0]          next_shift_in;
  logic [hsc_pkg::BIT_CNT_W-1:0]       bit_cnt;
  logic [hsc_pkg::BIT_CNT_W-1:0]       next_bit_cnt;
  logic [hsc_pkg::BYTE_CNT_W-1:0]      byte_cnt;
  logic [hsc_pkg::BYTE_CNT_W-1:0]      next_byte_cnt;
  logic [hsc_pkg::BYTE_W-1:0]          cmd_hold;
  logic [hsc_pkg::BYTE_W-1:0]          next_cmd_hold;
  logic [hsc_pkg::DATA_W-1:0]          data_hold;
  logic [hsc_pkg::DATA_W-1:0]          next_data_hold;
  logic [hsc_pkg::BYTE_W-1:0]          shift_out;
  logic [hsc_pkg::BYTE_W-1:0]          next_shift_out;
  logic                                next_reply_line;
  logic                                next_reply_oe;
  logic                                next_reply_next;
  logic                                next_cmd_valid;
  logic [hsc_pkg::BYTE_W-1:0]          next_cmd_byte;
  logic [hsc_pkg::DATA_W-1:0]          next_cmd_data;
  logic [hsc_pkg::BYTE_CNT_W-1:0]      next_cmd_count;
  logic [hsc_pkg::BYTE_W-1:0]          full_byte;

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb
  begin
    next_state      = state;
    next_shift_in   = shift_in;
    next_bit_cnt    = bit_cnt;
    next_byte_cnt   = byte_cnt;
    next_cmd_hold   = cmd_hold;
    next_data_hold  = data_hold;
    next_shift_out  = shift_out;
    next_reply_line = reply_line_o;
    next_reply_oe   = reply_line_oe_o;
    next_reply_next = 1'b0;
    next_cmd_valid  = 1'b0;
    next_cmd_byte   = cmd_byte_o;
    next_cmd_data   = cmd_data_o;
    next_cmd_count  = cmd_data_count_o;
    full_byte       = {shift_in[hsc_pkg::BYTE_W-2:0], link.data};
    case (state)
      hsc_pkg::HSC_IDLE:
      begin
        next_reply_oe = 1'b0;
        if (link.sel_start)
        begin
          next_state     = hsc_pkg::HSC_ACTIVE;
          next_bit_cnt   = hsc_pkg::BIT_RST;
          next_byte_cnt  = hsc_pkg::CNT_RST;
          next_shift_in  = hsc_pkg::BYTE_RST;
          next_shift_out = hsc_pkg::BYTE_RST;
          next_data_hold = hsc_pkg::DATA_RST;
        end
      end
      hsc_pkg::HSC_ACTIVE:
      begin
        if (link.sel_end)
        begin
          // release at once: well inside the allowed high-impedance time
          next_state    = hsc_pkg::HSC_IDLE;
          next_reply_oe = 1'b0;
          // a partial trailing byte is dropped; no command byte means no command
          if (byte_cnt != hsc_pkg::CNT_CMD)
          begin
            next_cmd_valid = 1'b1;
            next_cmd_byte  = cmd_hold;
            next_cmd_data  = data_hold;
            next_cmd_count = (byte_cnt == hsc_pkg::CNT_SAT) ? hsc_pkg::CNT_LO
                           : byte_cnt - hsc_pkg::CNT_HI;
          end
        end
        else
        begin
          if (link.sclk_rise)
          begin
            next_shift_in = full_byte;
            next_bit_cnt  = bit_cnt + 3'h1;
            if (bit_cnt == hsc_pkg::BIT_LAST)
            begin
              case (byte_cnt)
                hsc_pkg::CNT_CMD: next_cmd_hold = full_byte;
                hsc_pkg::CNT_HI:  next_data_hold[hsc_pkg::DATA_W-1:hsc_pkg::BYTE_W] = full_byte;
                hsc_pkg::CNT_LO:  next_data_hold[hsc_pkg::BYTE_W-1:0] = full_byte;
                default:          next_data_hold = data_hold;
              endcase
              if (byte_cnt != hsc_pkg::CNT_SAT)
              begin
                next_byte_cnt = byte_cnt + 2'h1;
              end
            end
          end
          if (link.sclk_fall)
          begin
            next_reply_oe = 1'b1;
            // a reply byte is loaded only once the command byte is in
            if ((bit_cnt == hsc_pkg::BIT_RST) && (byte_cnt != hsc_pkg::CNT_CMD))
            begin
              next_shift_out  = reply_byte_i;
              next_reply_line = reply_byte_i[hsc_pkg::BYTE_W-1];
              next_reply_next = 1'b1;
            end
            else
            begin
              next_shift_out  = {shift_out[hsc_pkg::BYTE_W-2:0], 1'b0};
              next_reply_line = shift_out[hsc_pkg::BYTE_W-2];
            end
          end
        end
      end
      default:
      begin
        next_state    = hsc_pkg::HSC_IDLE;
        next_reply_oe = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      state            <= hsc_pkg::HSC_IDLE;
      shift_in         <= hsc_pkg::BYTE_RST;
      bit_cnt          <= hsc_pkg::BIT_RST;
      byte_cnt         <= hsc_pkg::CNT_RST;
      cmd_hold         <= hsc_pkg::BYTE_RST;
      data_hold        <= hsc_pkg::DATA_RST;
      shift_out        <= hsc_pkg::BYTE_RST;
      reply_line_o     <= 1'b0;
      reply_line_oe_o  <= 1'b0;
      reply_next_o     <= 1'b0;
      cmd_valid_o      <= 1'b0;
      cmd_byte_o       <= hsc_pkg::BYTE_RST;
      cmd_data_o       <= hsc_pkg::DATA_RST;
      cmd_data_count_o <= hsc_pkg::CNT_RST;
    end
    else
    begin
      state            <= next_state;
      shift_in         <= next_shift_in;
      bit_cnt          <= next_bit_cnt;
      byte_cnt         <= next_byte_cnt;
      cmd_hold         <= next_cmd_hold;
      data_hold        <= next_data_hold;
      shift_out        <= next_shift_out;
      reply_line_o     <= next_reply_line;
      reply_line_oe_o  <= next_reply_oe;
      reply_next_o     <= next_reply_next;
      cmd_valid_o      <= next_cmd_valid;
      cmd_byte_o       <= next_cmd_byte;
      cmd_data_o       <= next_cmd_data;
      cmd_data_count_o <= next_cmd_count;
    end
  end

endmodule : hsc_cmd_port

`default_nettype wire

// [hsc_cmd_port_asserts.sv]
// Purpose : pin-level checks for the serial command port
// Assumes : two-flop sync, outputs registered after it
// Notes   : delays allow 2 cycles of sync before any response
`default_nettype none

module hsc_cmd_port_asserts (
  input wire logic        sys_clk_i,
  input wire logic        rst_n_i,
  input wire logic        serial_clock_i,
  input wire logic        chip_select_n_i,
  input wire logic        command_data_i,
  input wire logic        reply_line_o,
  input wire logic        reply_line_oe_o,
  input wire logic [7:0]  reply_byte_i,
  input wire logic        reply_next_o,
  input wire logic        cmd_valid_o,
  input wire logic [7:0]  cmd_byte_o,
  input wire logic [15:0] cmd_data_o,
  input wire logic [1:0]  cmd_data_count_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dc @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ----
  // checks
  // ----
  property p_one_data;
    cmd_valid_o && cmd_data_count_o == 2'h1 |-> cmd_data_o[7:0] == 8'h00;
  endproperty
  a_one_data: assert property (p_one_data) else $error("second byte not empty");
  property p_no_data;
    cmd_valid_o && cmd_data_count_o == 2'h0 |-> cmd_data_o == 16'h0000;
  endproperty
  a_no_data: assert property (p_no_data) else $error("data without bytes");
  property p_msb_out;
    reply_next_o |-> reply_line_o == $past(reply_byte_i[7]) && reply_line_oe_o;
  endproperty
  a_msb_out: assert property (p_msb_out) else $error("reply msb wrong");
  property p_on_end;
    cmd_valid_o |-> $past(chip_select_n_i, 2);
  endproperty
  a_on_end: assert property (p_on_end) else $error("command before select rose");
  property p_hold;
    !cmd_valid_o |-> $stable(cmd_byte_o) && $stable(cmd_data_o) && $stable(cmd_data_count_o);
  endproperty
  a_hold: assert property (p_hold) else $error("command changed early");
  property p_release;
    chip_select_n_i [*6] |-> !reply_line_oe_o;
  endproperty
  a_release: assert property (p_release) else $error("reply line not released");
  property p_late_drive;
    $rose(reply_line_oe_o) |-> !$past(chip_select_n_i, 2) && !$past(serial_clock_i, 2);
  endproperty
  a_late_drive: assert property (p_late_drive) else $error("reply driven early");
  property p_load_on_fall;
    reply_next_o |-> !$past(serial_clock_i, 2) && !$past(chip_select_n_i, 2);
  endproperty
  a_load_on_fall: assert property (p_load_on_fall) else $error("reply load off fall");
  c_two: cover property (cmd_valid_o && cmd_data_count_o == 2'h2);
  c_none: cover property (cmd_valid_o && cmd_data_count_o == 2'h0);
  c_next: cover property (reply_next_o);
endmodule : hsc_cmd_port_asserts

bind hsc_cmd_port hsc_cmd_port_asserts chk (.sys_clk_i, .rst_n_i, .serial_clock_i,
  .chip_select_n_i, .command_data_i, .reply_line_o, .reply_line_oe_o, .reply_byte_i,
  .reply_next_o, .cmd_valid_o, .cmd_byte_o, .cmd_data_o, .cmd_data_count_o);

`default_nettype wire

// [hsc_cmd_port_tb_top.sv]
// Purpose : self-checking bench for the serial command port
// Assumes : host model drives the link, bench plays the user side
// Notes   : released reply line reads inverted, never a held value
`default_nettype none

module hsc_cmd_port_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct { logic idle; int nbits; logic [23:0] tx; logic [15:0] rep; } hsc_row_s;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic sclk, chip_select_n, sdat, reply_w;
  logic reply_line_o, reply_line_oe_o, reply_next_o, cmd_valid_o;
  logic [7:0] reply_byte_i, cmd_byte_o;
  logic [15:0] cmd_data_o;
  logic [15:0] cur_rep = 16'h0000;
  logic [1:0] cmd_data_count_o;
  int n_errors = 0, samples_checked = 0, n_valid = 0, n_next = 0, base = 0, cyc = 0, r;
  hsc_row_s rows [5] = '{'{1'b0, 16, 24'hA53C00, 16'hB469}, '{1'b1, 24, 24'h5A817E, 16'hC3E1},
    '{1'b1, 8, 24'hC30000, 16'h0000}, '{1'b0, 24, 24'h0FF055, 16'h9A2D},
    '{1'b1, 16, 24'h81FF00, 16'h7E18}};
  always #20 sys_clk_i = ~sys_clk_i;
  assign reply_w = reply_line_oe_o ? reply_line_o : ~reply_line_o;
  assign reply_byte_i = (n_next == base) ? cur_rep[15:8] : cur_rep[7:0];
  hsc_host_model host (.serial_clock_o(sclk), .chip_select_n_o(chip_select_n), .command_data_o(sdat),
    .reply_line_i(reply_w));
  hsc_cmd_port dut (.sys_clk_i, .rst_n_i, .serial_clock_i(sclk), .chip_select_n_i(chip_select_n),
    .command_data_i(sdat), .reply_line_o, .reply_line_oe_o, .reply_byte_i, .reply_next_o,
    .cmd_valid_o, .cmd_byte_o, .cmd_data_o, .cmd_data_count_o);
  // ----
  // tasks
  // ----
  task automatic results;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic do_reset;
    @(posedge sys_clk_i);
    rst_n_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk("rst byte", 16'h0000, {8'h00, cmd_byte_o});
    chk("rst data", 16'h0000, cmd_data_o);
    chk("rst flags", 16'h0000, {10'h000, cmd_data_count_o, cmd_valid_o, reply_next_o,
        reply_line_oe_o, reply_line_o});
    @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    $display("test reset done");
  endtask : do_reset
  task automatic run_row(input hsc_row_s t);
    int v0;
    int k;
    logic [23:0] rx;
    logic [15:0] m;
    @(posedge sys_clk_i);
    cur_rep <= t.rep;
    base <= n_next;
    v0 = n_valid;
    host.xfer(t.idle, t.nbits, t.tx, rx);
    for (k = 0; k < 20 && n_valid == v0; k++)
      @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk("valid", 16'(t.nbits >= 8), 16'(n_valid - v0));
    if (t.nbits >= 8)
    begin
      chk("byte", {8'h00, t.tx[23:16]}, {8'h00, cmd_byte_o});
      chk("count", 16'(t.nbits >= 24 ? 2 : t.nbits / 8 - 1), {14'h0000, cmd_data_count_o});
      m = t.nbits >= 24 ? 16'hFFFF : (t.nbits >= 16 ? 16'hFF00 : 16'h0000);
      chk("data", t.tx[15:0] & m, cmd_data_o);
    end
    m = t.nbits >= 24 ? 16'hFFFF : (t.nbits >= 16 ? 16'h00FF : 16'h0000);
    chk("reply", (t.nbits >= 24 ? t.rep : {8'h00, t.rep[15:8]}) & m, rx[15:0] & m);
    chk("oe", 16'h0000, {15'h0000, reply_line_oe_o});
    $display("test bits %0d idle %b done", t.nbits, t.idle);
  endtask : run_row
  // ----
  // run
  // ----
  always @(posedge sys_clk_i)
  begin
    cyc <= cyc + 1;
    if (reply_next_o)
      n_next <= n_next + 1;
    if (cmd_valid_o)
      n_valid <= n_valid + 1;
    if (cyc == 5000)
    begin
      n_errors++;
      results();
    end
  end
  initial
  begin
    do_reset();
    for (r = 0; r < 5; r++)
      run_row(rows[r]);
    // partial last byte is dropped, and a frame with no whole byte is ignored
    run_row('{1'b0, 12, 24'h96F000, 16'h0000});
    run_row('{1'b1, 5, 24'hF80000, 16'h0000});
    do_reset();
    run_row(rows[1]);
    results();
  end
endmodule : hsc_cmd_port_tb_top

`default_nettype wire

// [hsc_edge_find.sv]
// Purpose : synchronises link pins and finds clock and select edges
// Assumes : link clock far slower than sys_clk_i
// Notes   : data travels beside the clock so both see the same delay
`default_nettype none

module hsc_edge_find (
  input  wire logic   sys_clk_i,
  input  wire logic   rst_n_i,
  input  wire logic   serial_clock_i,
  input  wire logic   chip_select_n_i,
  input  wire logic   command_data_i,
  hsc_link_if.src     link
);

  // ---------------------------------------------------------------
  // two-flop synchronisers, plus one history stage on clock and select
  // ---------------------------------------------------------------
  logic [2:0] clk_sr;
  logic [2:0] csn_sr;
  logic [1:0] dat_sr;
  logic [2:0] next_clk_sr;
  logic [2:0] next_csn_sr;
  logic [1:0] next_dat_sr;

  always_comb
  begin
    next_clk_sr = {clk_sr[1:0], serial_clock_i};
    next_csn_sr = {csn_sr[1:0], chip_select_n_i};
    next_dat_sr = {dat_sr[0], command_data_i};
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      clk_sr <= 3'h0;
      csn_sr <= 3'h7;
      dat_sr <= 2'h0;
    end
    else
    begin
      clk_sr <= next_clk_sr;
      csn_sr <= next_csn_sr;
      dat_sr <= next_dat_sr;
    end
  end

  // either idle level works: only transitions are reported
  assign link.sclk_rise = clk_sr[1] & ~clk_sr[2];
  assign link.sclk_fall = ~clk_sr[1] & clk_sr[2];
  assign link.sel       = ~csn_sr[1];
  assign link.sel_start = ~csn_sr[1] & csn_sr[2];
  assign link.sel_end   = csn_sr[1] & ~csn_sr[2];
  assign link.data      = dat_sr[1];

endmodule : hsc_edge_find

`default_nettype wire

// [hsc_host_model.sv]
// Purpose : host side of the serial command link
// Assumes : 320 ns link clock, low 200 ns so reply settles
// Notes   : clock stands at its idle level outside frames
`default_nettype none

module hsc_host_model (
  output logic         serial_clock_o,
  output logic         chip_select_n_o,
  output logic         command_data_o,
  input  wire logic    reply_line_i
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    serial_clock_o = 1'b0;
    chip_select_n_o = 1'b1;
    command_data_o = 1'b0;
  end
  task automatic xfer(input logic idle, input int nbits, input logic [23:0] tx,
                      output logic [23:0] rx);
    int i;
    rx = 24'h000000;
    // callers start on a system clock edge: step off it so pins never race the samplers
    #10;
    serial_clock_o = idle;
    #1000;
    chip_select_n_o = 1'b0;
    #160;
    for (i = 0; i < nbits; i++)
    begin
      serial_clock_o = 1'b0;
      command_data_o = tx[23-i];
      #200;
      serial_clock_o = 1'b1;
      rx = {rx[22:0], reply_line_i};
      #120;
    end
    serial_clock_o = idle;
    #160;
    chip_select_n_o = 1'b1;
    command_data_o = ~command_data_o;
  endtask : xfer
endmodule : hsc_host_model

`default_nettype wire

// [hsc_link_if.sv]
// Purpose : carries synchronised link events from edge finder to port
// Assumes : one system clock domain
// Notes   : all members are driven by the edge finder
`default_nettype none

interface hsc_link_if;
  logic sclk_rise;
  logic sclk_fall;
  logic sel;
  logic sel_start;
  logic sel_end;
  logic data;

  modport src (output sclk_rise, output sclk_fall, output sel,
               output sel_start, output sel_end, output data);
  modport snk (input sclk_rise, input sclk_fall, input sel,
               input sel_start, input sel_end, input data);
endinterface : hsc_link_if

`default_nettype wire

// [hsc_pkg.sv]
// Purpose : constants for the host serial command port
// Assumes : 25 MHz system clock
// Notes   : used by the command port only
`default_nettype none

package hsc_pkg;

  // ---------------------------------------------------------------
  // data layout
  // ---------------------------------------------------------------
  localparam int unsigned BYTE_W      = 8;
  localparam int unsigned BIT_CNT_W   = 3;
  localparam int unsigned BYTE_CNT_W  = 2;
  localparam int unsigned DATA_BYTES  = 2;
  localparam int unsigned DATA_W      = DATA_BYTES * BYTE_W;
  localparam int unsigned SYNC_STAGES = 2;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [BYTE_W-1:0]     BYTE_RST  = 8'h00;
  localparam logic [DATA_W-1:0]     DATA_RST  = 16'h0000;
  localparam logic [BIT_CNT_W-1:0]  BIT_RST   = 3'h0;
  localparam logic [BIT_CNT_W-1:0]  BIT_LAST  = 3'h7;
  localparam logic [BYTE_CNT_W-1:0] CNT_RST   = 2'h0;
  localparam logic [BYTE_CNT_W-1:0] CNT_CMD   = 2'h0;
  localparam logic [BYTE_CNT_W-1:0] CNT_HI    = 2'h1;
  localparam logic [BYTE_CNT_W-1:0] CNT_LO    = 2'h2;
  localparam logic [BYTE_CNT_W-1:0] CNT_SAT   = 2'h3;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_KHZ      = 25000;
  localparam int unsigned HIZ_MAX_NS   = 1000;
  localparam int unsigned HIZ_MAX_CYC  = (HIZ_MAX_NS * CLK_KHZ) / 1000000;
  localparam int unsigned CSOFF_MIN_NS = 1000;

  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    HSC_IDLE   = 2'b00,
    HSC_ACTIVE = 2'b01
  } hsc_state_e;

endpackage : hsc_pkg

`default_nettype wire
